// ---- hw/adc_channel_path.sv ----
`timescale 1ns/1ns
`default_nettype none
module adc_channel_path
    import adc_ctrl_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    channel_regs_if.path regs,
    input wire logic [SAMPLE_W-1:0] sample_i,
    input wire logic [SAMPLE_W*USER_PATTERNS-1:0] user_pattern_i,
    output logic [SAMPLE_W-1:0] data_o,
    output logic data_en_o
);
    // ==========================================================
    // pseudo-random generators
    logic [PN_LONG_W-1:0] long_pseudo_random_generator;
    logic [PN_SHORT_W-1:0] short_pseudo_random_generator;
    logic [1:0] user_idx;
    logic user_done;
    wire [3:0] sel = regs.test_pattern[TP_SEL_LSB +: TP_SEL_W];
    wire single = regs.test_pattern[BIT_TP_SINGLE];
    wire toggle_phase = user_idx[0];
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            long_pseudo_random_generator <= PN_LONG_SEED;
            short_pseudo_random_generator <= PN_SHORT_SEED;
        end else begin
            if (regs.test_pattern[BIT_TP_RESET_LONG]) begin
                long_pseudo_random_generator <= PN_LONG_SEED;
            end else begin
                long_pseudo_random_generator <= {
                    long_pseudo_random_generator[PN_LONG_W-2:0],
                    long_pseudo_random_generator[22]
                    ^ long_pseudo_random_generator[17]};
            end
            if (regs.test_pattern[BIT_TP_RESET_SHORT]) begin
                short_pseudo_random_generator <= PN_SHORT_SEED;
            end else begin
                short_pseudo_random_generator <= {
                    short_pseudo_random_generator[PN_SHORT_W-2:0],
                    short_pseudo_random_generator[8]
                    ^ short_pseudo_random_generator[4]};
            end
        end
    end
    // ==========================================================
    // user pattern playback
    // repeat or single
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            user_idx <= 2'h0;
            user_done <= 1'b0;
        end else if (sel != TP_USER) begin
            user_idx <= user_idx + 2'h1;
            user_done <= 1'b0;
        end else begin
            user_idx <= user_idx + 2'h1;
            if (single && user_idx == 2'h3) begin
                user_done <= 1'b1;
            end
        end
    end
    // ==========================================================
    // conversion path
    // offset trim add
    wire [SAMPLE_W-1:0] trim = SAMPLE_W'($signed(
        regs.offset_trim[OFFSET_W-1:0]));
    wire [SAMPLE_W-1:0] trimmed = sample_i + trim;
    logic [SAMPLE_W-1:0] pattern;
    logic [SAMPLE_W-1:0] fmt;
    always_comb begin
        pattern = '0;
        unique case (sel)
            TP_MID: pattern = {1'b1, {(SAMPLE_W-1){1'b0}}};
            TP_POS_FS: pattern = {SAMPLE_W{1'b1}};
            TP_NEG_FS: pattern = '0;
            TP_CHECKER: pattern = toggle_phase ?
                {(SAMPLE_W/2){2'b01}} : {(SAMPLE_W/2){2'b10}};
            TP_PN_LONG: pattern =
                long_pseudo_random_generator[SAMPLE_W-1:0];
            TP_PN_SHORT: pattern = {
                short_pseudo_random_generator,
                short_pseudo_random_generator[SAMPLE_W-PN_SHORT_W-1:0]};
            TP_TOGGLE: pattern = toggle_phase ? {SAMPLE_W{1'b1}} : '0;
            TP_USER: pattern = user_done ? '0 :
                user_pattern_i[user_idx*SAMPLE_W +: SAMPLE_W];
            default: pattern = '0;
        endcase
    end
    always_comb begin
        fmt = trimmed ^ {1'b1, {(SAMPLE_W-1){1'b0}}};
        unique case (regs.output_format[FMT_LSB +: FMT_W])
            FMT_OFFSET_BIN: fmt = trimmed ^ {1'b1, {(SAMPLE_W-1){1'b0}}};
            FMT_TWOS: fmt = trimmed;
            FMT_GRAY: fmt = (trimmed ^ {1'b1, {(SAMPLE_W-1){1'b0}}})
                ^ ((trimmed ^ {1'b1, {(SAMPLE_W-1){1'b0}}}) >> 1);
            default: fmt = trimmed;
        endcase
        if (!regs.output_format[BIT_OUT_INVERT]) begin
            fmt = ~fmt;
        end
    end
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_o <= '0;
            data_en_o <= 1'b0;
        end else begin
            data_o <= (sel != TP_OFF) ? pattern : fmt;
            data_en_o <= !regs.output_format[BIT_OUT_ENABLE_N];
        end
    end
endmodule : adc_channel_path
`default_nettype wire

// ---- hw/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SAMPLE_W = 14;
    localparam int NUM_CH = 2;
    localparam int CH_W = 1;
    // register offsets
    localparam logic [7:0] OFF_CHANNEL_SELECT = 8'h05;
    localparam logic [7:0] OFF_POWER_MODE = 8'h08;
    localparam logic [7:0] OFF_SAMPLE_CLOCK = 8'h09;
    localparam logic [7:0] OFF_CLOCK_DIVIDER = 8'h0B;
    localparam logic [7:0] OFF_TEST_PATTERN = 8'h0D;
    localparam logic [7:0] OFF_OFFSET_TRIM = 8'h10;
    localparam logic [7:0] OFF_OUTPUT_FORMAT = 8'h14;
    localparam logic [7:0] OFF_DRIVE_STRENGTH = 8'h15;
    localparam logic [7:0] OFF_CLOCK_PHASE = 8'h16;
    localparam logic [7:0] OFF_TRANSFER = 8'hFF;
    // reset values
    localparam logic [7:0] RST_CHANNEL_SELECT = 8'h03;
    localparam logic [7:0] RST_POWER_MODE = 8'h00;
    localparam logic [7:0] RST_SAMPLE_CLOCK = 8'h01;
    localparam logic [7:0] RST_CLOCK_DIVIDER = 8'h00;
    localparam logic [7:0] RST_TEST_PATTERN = 8'h00;
    localparam logic [7:0] RST_OFFSET_TRIM = 8'h00;
    localparam logic [7:0] RST_OUTPUT_FORMAT = 8'h05;
    localparam logic [7:0] RST_DRIVE_STRENGTH = 8'h01;
    localparam logic [7:0] RST_CLOCK_PHASE = 8'h00;
    // field positions
    localparam int BIT_PDWN_STANDBY = 5;
    localparam int BIT_STABILIZER = 0;
    localparam int DIV_RATIO_LSB = 0;
    localparam int DIV_PHASE_LSB = 3;
    localparam int DIV_FIELD_W = 3;
    localparam int TP_SEL_LSB = 0;
    localparam int TP_SEL_W = 4;
    localparam int BIT_TP_RESET_SHORT = 4;
    localparam int BIT_TP_RESET_LONG = 5;
    localparam int BIT_TP_SINGLE = 7;
    localparam int OFFSET_W = 6;
    localparam int FMT_LSB = 0;
    localparam int FMT_W = 2;
    localparam int BIT_OUT_INVERT = 2;
    localparam int BIT_OUT_ENABLE_N = 4;
    localparam int DRIVE_W = 4;
    localparam int BIT_EVEN_ODD = 5;
    localparam int BIT_CLOCK_INVERT = 7;
    localparam int BIT_TRANSFER = 0;
    // output formats
    localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
    localparam logic [1:0] FMT_TWOS = 2'h1;
    localparam logic [1:0] FMT_GRAY = 2'h2;
    // test pattern codes
    localparam logic [3:0] TP_OFF = 4'h0;
    localparam logic [3:0] TP_MID = 4'h1;
    localparam logic [3:0] TP_POS_FS = 4'h2;
    localparam logic [3:0] TP_NEG_FS = 4'h3;
    localparam logic [3:0] TP_CHECKER = 4'h4;
    localparam logic [3:0] TP_PN_LONG = 4'h5;
    localparam logic [3:0] TP_PN_SHORT = 4'h6;
    localparam logic [3:0] TP_TOGGLE = 4'h7;
    localparam logic [3:0] TP_USER = 4'h8;
    localparam int USER_PATTERNS = 4;
    localparam int PN_LONG_W = 23;
    localparam int PN_SHORT_W = 9;
    localparam logic [22:0] PN_LONG_SEED = 23'h7FFFFF;
    localparam logic [8:0] PN_SHORT_SEED = 9'h1FF;
endpackage : adc_ctrl_pkg

// ---- hw/adc_function_control_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
module adc_function_control_regs
    import adc_ctrl_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic power_down_pin_i,
    input wire logic [SAMPLE_W-1:0] sample_a_i,
    input wire logic [SAMPLE_W-1:0] sample_b_i,
    input wire logic [SAMPLE_W*USER_PATTERNS-1:0] user_pattern_i,
    output logic [SAMPLE_W-1:0] data_a_o,
    output logic [SAMPLE_W-1:0] data_b_o,
    output logic [NUM_CH-1:0] data_en_o,
    output logic [NUM_CH-1:0] full_power_down_o,
    output logic [NUM_CH-1:0] standby_o,
    output logic stabilizer_on_o,
    output logic sample_clock_o,
    output logic [DRIVE_W-1:0] drive_strength_o,
    output logic output_data_clock_invert_o,
    output logic even_odd_mode_o
);
    // ==========================================================
    // pin synchroniser
    logic [2:0] pdwn_sync;
    logic pdwn;
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pdwn_sync <= 3'h0;
            pdwn <= 1'b0;
        end else begin
            pdwn_sync <= {pdwn_sync[1:0], power_down_pin_i};
            if (pdwn_sync[2] == pdwn_sync[1]) begin
                pdwn <= pdwn_sync[2];
            end
        end
    end
    // ==========================================================
    // shadow and active registers
    logic [NUM_CH-1:0] ch_sel;
    logic [7:0] sh_power [NUM_CH];
    logic [7:0] sh_test [NUM_CH];
    logic [7:0] sh_offset [NUM_CH];
    logic [7:0] sh_format [NUM_CH];
    logic [7:0] sh_clock, sh_divider, sh_drive, sh_phase;
    logic [7:0] act_clock, act_divider, act_drive, act_phase;
    channel_regs_if ch_if [NUM_CH] ();
    wire logic [NUM_CH-1:0] pin_standby;
    wire do_transfer = wr_en_i && addr_i == OFF_TRANSFER
        && wdata_i[BIT_TRANSFER];
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ch_sel <= RST_CHANNEL_SELECT[NUM_CH-1:0];
        end else if (wr_en_i && addr_i == OFF_CHANNEL_SELECT) begin
            ch_sel <= wdata_i[NUM_CH-1:0];
        end
    end
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sh_clock <= RST_SAMPLE_CLOCK;
            sh_divider <= RST_CLOCK_DIVIDER;
            sh_drive <= RST_DRIVE_STRENGTH;
            sh_phase <= RST_CLOCK_PHASE;
            act_clock <= RST_SAMPLE_CLOCK;
            act_divider <= RST_CLOCK_DIVIDER;
            act_drive <= RST_DRIVE_STRENGTH;
            act_phase <= RST_CLOCK_PHASE;
        end else begin
            if (wr_en_i && addr_i == OFF_SAMPLE_CLOCK) sh_clock <= wdata_i;
            if (wr_en_i && addr_i == OFF_CLOCK_DIVIDER) sh_divider <= wdata_i;
            if (wr_en_i && addr_i == OFF_DRIVE_STRENGTH) sh_drive <= wdata_i;
            if (wr_en_i && addr_i == OFF_CLOCK_PHASE) sh_phase <= wdata_i;
            if (do_transfer) begin
                act_clock <= sh_clock;
                act_divider <= sh_divider;
                act_drive <= sh_drive;
                act_phase <= sh_phase;
            end
        end
    end
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic [7:0] a_power, a_test, a_offset, a_format;
        wire wr_ch = wr_en_i && ch_sel[c];
        always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                sh_power[c] <= RST_POWER_MODE;
                sh_test[c] <= RST_TEST_PATTERN;
                sh_offset[c] <= RST_OFFSET_TRIM;
                sh_format[c] <= RST_OUTPUT_FORMAT;
                a_power <= RST_POWER_MODE;
                a_test <= RST_TEST_PATTERN;
                a_offset <= RST_OFFSET_TRIM;
                a_format <= RST_OUTPUT_FORMAT;
            end else begin
                if (wr_ch && addr_i == OFF_POWER_MODE) sh_power[c] <= wdata_i;
                if (wr_ch && addr_i == OFF_TEST_PATTERN) sh_test[c] <= wdata_i;
                if (wr_ch && addr_i == OFF_OFFSET_TRIM)
                    sh_offset[c] <= wdata_i;
                if (wr_ch && addr_i == OFF_OUTPUT_FORMAT)
                    sh_format[c] <= wdata_i;
                if (do_transfer) begin
                    a_power <= sh_power[c];
                    a_test <= sh_test[c];
                    a_offset <= sh_offset[c];
                    a_format <= sh_format[c];
                end
            end
        end
        assign ch_if[c].power_mode = a_power;
        assign ch_if[c].test_pattern = a_test;
        assign ch_if[c].offset_trim = a_offset;
        assign ch_if[c].output_format = a_format;
        assign pin_standby[c] = a_power[BIT_PDWN_STANDBY];
    end
    // ==========================================================
    // channel datapaths
    adc_channel_path path_a (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .regs(ch_if[0]),
        .sample_i(sample_a_i),
        .user_pattern_i(user_pattern_i),
        .data_o(data_a_o),
        .data_en_o(data_en_o[0])
    );
    adc_channel_path path_b (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .regs(ch_if[1]),
        .sample_i(sample_b_i),
        .user_pattern_i(user_pattern_i),
        .data_o(data_b_o),
        .data_en_o(data_en_o[1])
    );
    // ==========================================================
    // sample clock divider
    logic [DIV_FIELD_W-1:0] div_cnt;
    logic [DIV_FIELD_W-1:0] phase_cnt;
    logic phase_wait;
    wire [DIV_FIELD_W-1:0] ratio = act_divider[DIV_RATIO_LSB +: DIV_FIELD_W];
    wire [DIV_FIELD_W-1:0] phase = act_divider[DIV_PHASE_LSB +: DIV_FIELD_W];
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_cnt <= '0;
            phase_cnt <= '0;
            phase_wait <= 1'b1;
            sample_clock_o <= 1'b0;
        end else if (do_transfer) begin
            div_cnt <= '0;
            phase_cnt <= '0;
            phase_wait <= 1'b1;
            sample_clock_o <= 1'b0;
        end else if (phase_wait) begin
            phase_cnt <= phase_cnt + 1'b1;
            if (phase_cnt >= phase) phase_wait <= 1'b0;
        end else begin
            div_cnt <= (div_cnt >= ratio) ? '0 : div_cnt + 1'b1;
            sample_clock_o <= (div_cnt == '0);
        end
    end
    // ==========================================================
    // per-channel power outputs, global outputs and readback
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (addr_i)
            OFF_CHANNEL_SELECT: rd_mux = {6'h00, ch_sel};
            OFF_POWER_MODE: rd_mux = ch_sel[0] ? sh_power[0] : sh_power[1];
            OFF_SAMPLE_CLOCK: rd_mux = sh_clock;
            OFF_CLOCK_DIVIDER: rd_mux = sh_divider;
            OFF_TEST_PATTERN: rd_mux = ch_sel[0] ? sh_test[0] : sh_test[1];
            OFF_OFFSET_TRIM: rd_mux = ch_sel[0] ? sh_offset[0] : sh_offset[1];
            OFF_OUTPUT_FORMAT: rd_mux = ch_sel[0] ? sh_format[0]
                : sh_format[1];
            OFF_DRIVE_STRENGTH: rd_mux = sh_drive;
            OFF_CLOCK_PHASE: rd_mux = sh_phase;
            default: rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 8'h00;
            full_power_down_o <= '0;
            standby_o <= '0;
            stabilizer_on_o <= 1'b1;
            drive_strength_o <= RST_DRIVE_STRENGTH[DRIVE_W-1:0];
            output_data_clock_invert_o <= 1'b0;
            even_odd_mode_o <= 1'b0;
        end else begin
            rdata_o <= rd_mux;
            for (int c = 0; c < NUM_CH; c++) begin
                full_power_down_o[c] <= pdwn && !pin_standby[c];
                standby_o[c] <= pdwn && pin_standby[c];
            end
            stabilizer_on_o <= act_clock[BIT_STABILIZER] || (ratio != '0);
            drive_strength_o <= act_drive[DRIVE_W-1:0];
            output_data_clock_invert_o <= act_phase[BIT_CLOCK_INVERT];
            even_odd_mode_o <= act_phase[BIT_EVEN_ODD];
        end
    end
endmodule : adc_function_control_regs
`default_nettype wire

// ---- hw/channel_regs_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface channel_regs_if;
    logic [7:0] power_mode;
    logic [7:0] test_pattern;
    logic [7:0] offset_trim;
    logic [7:0] output_format;
    modport ctrl (output power_mode, test_pattern, offset_trim,
        output_format);
    modport path (input power_mode, test_pattern, offset_trim,
        output_format);
endinterface : channel_regs_if
`default_nettype wire

// ---- sim/adc_ctrl_props.sv ----
`timescale 1ns/1ns
`default_nettype none
// ====================
// control register checks
module adc_ctrl_props
    import adc_ctrl_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic power_down_pin_i,
    input wire logic [NUM_CH-1:0] full_power_down_o,
    input wire logic [NUM_CH-1:0] standby_o,
    input wire logic stabilizer_on_o,
    input wire logic sample_clock_o,
    input wire logic [DRIVE_W-1:0] drive_strength_o,
    input wire logic output_data_clock_invert_o,
    input wire logic even_odd_mode_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [7:0] sh_clk, sh_div, sh_drv, sh_ph, act_clk, act_div;
    logic xfer_q;
    wire logic xfer = wr_en_i && addr_i == OFF_TRANSFER
        && wdata_i[BIT_TRANSFER];
    wire logic wr_clk = wr_en_i && addr_i == OFF_SAMPLE_CLOCK;
    wire logic wr_div = wr_en_i && addr_i == OFF_CLOCK_DIVIDER;
    wire logic wr_drv = wr_en_i && addr_i == OFF_DRIVE_STRENGTH;
    wire logic wr_ph = wr_en_i && addr_i == OFF_CLOCK_PHASE;
    wire logic stab_exp = act_clk[BIT_STABILIZER] || act_div[2:0] != 3'h0;
    // shadow copies of the global registers, active copies of sample clock and divider only
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sh_clk <= RST_SAMPLE_CLOCK;
            act_clk <= RST_SAMPLE_CLOCK;
            sh_div <= RST_CLOCK_DIVIDER;
            act_div <= RST_CLOCK_DIVIDER;
            sh_drv <= RST_DRIVE_STRENGTH;
            sh_ph <= RST_CLOCK_PHASE;
            xfer_q <= 1'b0;
        end else begin
            sh_clk <= wr_clk ? wdata_i : sh_clk;
            sh_div <= wr_div ? wdata_i : sh_div;
            sh_drv <= wr_drv ? wdata_i : sh_drv;
            sh_ph <= wr_ph ? wdata_i : sh_ph;
            act_clk <= xfer ? sh_clk : act_clk;
            act_div <= xfer ? sh_div : act_div;
            xfer_q <= xfer;
        end
    end
    sequence gap_two;
        !sample_clock_o ##1 !sample_clock_o ##1 sample_clock_o;
    endsequence
    sequence steady_div3;
        sample_clock_o && act_div[2:0] == 3'h2 && !xfer && !xfer_q;
    endsequence
    property drive_p;
        logic [DRIVE_W-1:0] v;
        (xfer, v = sh_drv[DRIVE_W-1:0]) |-> ##2 drive_strength_o == v;
    endproperty
    property phase_p;
        logic [7:0] v;
        (xfer, v = sh_ph) |-> ##2 (output_data_clock_invert_o ==
            v[BIT_CLOCK_INVERT] && even_odd_mode_o == v[BIT_EVEN_ODD]);
    endproperty
    drive_xfer_a: assert property (drive_p)
        else $error("drive strength not applied on transfer");
    globals_hold_a: assert property ((!xfer && !xfer_q) |=>
        $stable({drive_strength_o, output_data_clock_invert_o,
        even_odd_mode_o})) else $error("global output moved unasked");
    phase_ctrl_a: assert property (phase_p)
        else $error("clock phase control not applied");
    stab_forced_a: assert property ((act_clk == $past(act_clk) &&
        act_div == $past(act_div)) |-> stabilizer_on_o == stab_exp)
        else $error("stabilizer state wrong");
    div_three_a: assert property (steady_div3 |=>
        gap_two or ##[0:2] xfer) else $error("divide by three broken");
    power_excl_a: assert property ((full_power_down_o & standby_o)
        == 2'h0) else $error("power down and standby together");
    pin_low_a: assert property ((!power_down_pin_i) [*6] |->
        (full_power_down_o | standby_o) == 2'h0)
        else $error("power state without pin");
    pin_high_a: assert property (power_down_pin_i [*6] |->
        (full_power_down_o | standby_o) == 2'h3)
        else $error("pin did not power channels down");
endmodule : adc_ctrl_props
bind adc_function_control_regs adc_ctrl_props adc_ctrl_props_i (
    .ref_clk_i, .reset_n_i, .wr_en_i, .addr_i, .wdata_i, .power_down_pin_i,
    .full_power_down_o, .standby_o, .stabilizer_on_o, .sample_clock_o,
    .drive_strength_o, .output_data_clock_invert_o, .even_odd_mode_o);
`default_nettype wire

// ---- sim/cfg_host.sv ----
`timescale 1ns/1ns
`default_nettype none
// ====================
// configuration host model
module cfg_host
    import adc_ctrl_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic [DATA_W-1:0] rdata_i,
    output logic wr_en_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] wdata_o
);
    initial begin
        wr_en_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #5;
        wr_en_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(posedge ref_clk_i);
        #5;
        wr_en_o = 1'b0;
        wdata_o = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        #5;
        addr_o = a;
        @(posedge ref_clk_i);
        #1;
        d = rdata_i;
    endtask : rd
    task automatic pick(input logic [7:0] mask);
        wr(OFF_CHANNEL_SELECT, mask);
    endtask : pick
    task automatic commit;
        wr(OFF_TRANSFER, 8'h01);
    endtask : commit
endmodule : cfg_host
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
// ====================
// testbench top
module tb;
    import adc_ctrl_pkg::*;
    localparam logic [13:0] SA = 14'h0123;
    localparam logic [13:0] SB = 14'h0456;
    localparam logic [13:0] OB = SA ^ 14'h2000;
    localparam logic [55:0] UP = {14'h0444, 14'h0333, 14'h0222, 14'h0111};
    logic ref_clk_i, reset_n_i, wr_en, pin, stab, sclk, clk_inv, even_odd;
    logic [7:0] addr, wdata, rdata, rv;
    logic [13:0] data_a, data_b, d1;
    logic [1:0] data_en, full_pd, standby;
    logic [3:0] drive;
    int failures, cmp_count, n, t0, t6;
    logic [7:0] reg_off [8] = '{OFF_POWER_MODE, OFF_SAMPLE_CLOCK,
        OFF_CLOCK_DIVIDER, OFF_TEST_PATTERN, OFF_OFFSET_TRIM,
        OFF_OUTPUT_FORMAT, OFF_DRIVE_STRENGTH, OFF_CLOCK_PHASE};
    logic [7:0] reg_rst [8] = '{RST_POWER_MODE, RST_SAMPLE_CLOCK,
        RST_CLOCK_DIVIDER, RST_TEST_PATTERN, RST_OFFSET_TRIM,
        RST_OUTPUT_FORMAT, RST_DRIVE_STRENGTH, RST_CLOCK_PHASE};
    logic [7:0] fmt_code [4] = '{8'h01, 8'h04, 8'h06, 8'h05};
    logic [13:0] fmt_exp [4] = '{~SA, OB, OB ^ (OB >> 1), SA};
    logic [7:0] trim_code [3] = '{8'h1F, 8'h3F, 8'h00};
    logic [13:0] trim_exp [3] = '{SB + 14'h001F, SB - 14'h0001, SB};
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    adc_function_control_regs adc_function_control_regs_i (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_en),
        .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
        .power_down_pin_i(pin), .sample_a_i(SA), .sample_b_i(SB),
        .user_pattern_i(UP), .data_a_o(data_a), .data_b_o(data_b),
        .data_en_o(data_en), .full_power_down_o(full_pd),
        .standby_o(standby), .stabilizer_on_o(stab),
        .sample_clock_o(sclk), .drive_strength_o(drive),
        .output_data_clock_invert_o(clk_inv), .even_odd_mode_o(even_odd));
    cfg_host cfg_host_i (.ref_clk_i(ref_clk_i), .rdata_i(rdata),
        .wr_en_o(wr_en), .addr_o(addr), .wdata_o(wdata));
    // ====================
    // helper tasks
    task automatic check(input string what, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic settle;
        repeat (6) @(posedge ref_clk_i);
        #1;
    endtask : settle
    task automatic xfer;
        cfg_host_i.commit();
        settle();
    endtask : xfer
    task automatic drive_pin(input logic v);
        @(posedge ref_clk_i);
        #5;
        pin = v;
        repeat (8) @(posedge ref_clk_i);
        #1;
    endtask : drive_pin
    task automatic pulse_at(output int t);
        cfg_host_i.commit();
        t = 0;
        do begin
            @(posedge ref_clk_i);
            #1;
            t++;
        end while (sclk !== 1'b1 && t < 40);
        if (sclk !== 1'b1) failures++;
    endtask : pulse_at
    task automatic end_of_test;
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        failures++;
        end_of_test();
    end
    // ====================
    // main sequence
    initial begin
        reset_n_i = 1'b0;
        pin = 1'b0;
        failures = 0;
        cmp_count = 0;
        repeat (3) @(posedge ref_clk_i);
        #5;
        reset_n_i = 1'b1;
        for (int i = 0; i < 8; i++) begin
            cfg_host_i.rd(reg_off[i], rv);
            check("reset value", rv, reg_rst[i]);
        end
        cfg_host_i.rd(8'h30, rv);
        check("unmapped read", rv, 8'h00);
        cfg_host_i.pick(8'h01);
        d1 = SA;
        for (int i = 0; i < 4; i++) begin
            cfg_host_i.wr(OFF_OUTPUT_FORMAT, fmt_code[i]);
            settle();
            check("data a before transfer", data_a, d1);
            xfer();
            check("data a format", data_a, fmt_exp[i]);
            check("data b untouched", data_b, SB);
            d1 = fmt_exp[i];
        end
        cfg_host_i.wr(OFF_OUTPUT_FORMAT, 8'h15);
        xfer();
        check("output enable off", data_en, 2'h2);
        cfg_host_i.wr(OFF_OUTPUT_FORMAT, 8'h05);
        xfer();
        check("output enable on", data_en, 2'h3);
        cfg_host_i.wr(OFF_TEST_PATTERN, 8'h08);
        xfer();
        n = 0;
        while (data_a !== UP[13:0] && n < 8) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        check("user pattern", data_a, UP[13:0]);
        @(posedge ref_clk_i);
        #1;
        check("user pattern next", data_a, UP[27:14]);
        cfg_host_i.wr(OFF_TEST_PATTERN, 8'h88);
        xfer();
        repeat (8) @(posedge ref_clk_i);
        #1;
        check("single pattern end", data_a, 14'h0000);
        for (int i = 0; i < 2; i++) begin
            cfg_host_i.wr(OFF_TEST_PATTERN,
                {4'h0, i == 0 ? TP_PN_LONG : TP_PN_SHORT});
            xfer();
            d1 = data_a;
            @(posedge ref_clk_i);
            #1;
            check("pseudo random moves", data_a !== d1, 1'b1);
        end
        cfg_host_i.wr(OFF_TEST_PATTERN, {4'h0, TP_TOGGLE});
        xfer();
        d1 = data_a;
        @(posedge ref_clk_i);
        #1;
        check("toggle pattern", data_a ^ d1, 14'h3FFF);
        cfg_host_i.wr(OFF_TEST_PATTERN, 8'h00);
        xfer();
        check("converter data back", data_a, SA);
        cfg_host_i.pick(8'h02);
        for (int i = 0; i < 3; i++) begin
            cfg_host_i.wr(OFF_OFFSET_TRIM, trim_code[i]);
            xfer();
            check("offset trim", data_b, trim_exp[i]);
        end
        cfg_host_i.wr(OFF_POWER_MODE, 8'h20);
        xfer();
        drive_pin(1'b1);
        check("pin power states", {full_pd, standby}, 4'h6);
        drive_pin(1'b0);
        check("pin released", {full_pd, standby}, 4'h0);
        cfg_host_i.wr(OFF_SAMPLE_CLOCK, 8'h00);
        cfg_host_i.wr(OFF_CLOCK_DIVIDER, 8'h02);
        xfer();
        check("stabilizer forced", stab, 1'b1);
        n = 0;
        repeat (30) begin
            @(posedge ref_clk_i);
            #1;
            if (sclk === 1'b1) n++;
        end
        check("divided pulses", 16'(n), 16'h000A);
        cfg_host_i.wr(OFF_CLOCK_DIVIDER, 8'h06);
        pulse_at(t0);
        cfg_host_i.wr(OFF_CLOCK_DIVIDER, 8'h36);
        pulse_at(t6);
        check("phase delay", 16'(t6 - t0), 16'h0006);
        cfg_host_i.wr(OFF_CLOCK_DIVIDER, 8'h00);
        xfer();
        check("stabilizer released", stab, 1'b0);
        check("undivided clock", sclk, 1'b1);
        cfg_host_i.wr(OFF_DRIVE_STRENGTH, 8'h07);
        cfg_host_i.wr(OFF_CLOCK_PHASE, 8'hA0);
        settle();
        check("drive before transfer", drive, 4'h1);
        xfer();
        check("drive after transfer", drive, 4'h7);
        check("clock invert even odd", {clk_inv, even_odd}, 2'h3);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
